// ==== pkg/adc_cfg.svh ====
// Constants for the channel configuration register bank
`ifndef ADC_CFG_SVH_CFG
`define ADC_CFG_SVH_CFG

// ----------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_W 10
`define IDX_RANGE_34 10'h004
`define IDX_RANGE_56 10'h005
`define IDX_RANGE_78 10'h006
`define IDX_BANDWIDTH 10'h007
`define IDX_AVERAGING 10'h008
`define IDX_GAIN_CH1 10'h009
`define IDX_MODE_CTRL 10'h030
`define IDX_SEQ_STATUS 10'h031

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_RANGE 8'h33
`define RST_BANDWIDTH 8'h00
`define RST_AVERAGING 8'h00
`define RST_GAIN 6'h00
`define RST_MODE 1'b0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define REG_W 8
`define EVEN_MSB 7
`define EVEN_LSB 4
`define ODD_MSB 3
`define ODD_LSB 0
`define PAD_MSB 7
`define PAD_LSB 4
`define RATIO_MSB 3
`define RATIO_LSB 0
`define GAIN_MSB 5
`define GAIN_LSB 0
`define GAIN_W 6
`define EXT_CLK_BIT 0

// ----------------------------------------------------------------
// Span and ratio codes
// ----------------------------------------------------------------
`define SPAN_BIP_LAST 4'h4
`define SPAN_UNI_LAST 4'h7
`define SPAN_DIFF_FIRST 4'h8
`define SPAN_DIFF_LAST 4'hb
`define RATIO_OFF 4'h0
`define RATIO_MAX 4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define REF_CLK_MHZ 40
`define SAMPLE_GAP_NS 1000
`define PAD_STEP_NS 100

`endif

// ==== pkg/adc_cfg_pkg.sv ====
// Types shared by the channel configuration register bank
package adc_cfg_pkg;

	// Averaging sequencer states
	typedef enum logic {
		OS_IDLE,
		OS_RUN
	} os_state_t;

endpackage

// ==== pkg/span_if.sv ====
// Carrier between a range register field and its span decoder
`timescale 1ns/10ps
interface span_if;
	logic [3:0] code;
	logic bipolar;
	logic unipolar;
	logic differential;
	logic defined;

	modport src (output code, input bipolar, input unipolar, input differential, input defined);
	modport dec (input code, output bipolar, output unipolar, output differential, output defined);
endinterface

// ==== design/span_decode.sv ====
// Decoder of one four-bit input span selector into span class flags
`timescale 1ns/10ps
`include "adc_cfg.svh"
module span_decode
	import adc_cfg_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Selector in, flags out
	span_if.dec sp
);

	// ----------------------------------------------------------------
	// Code classes
	// ----------------------------------------------------------------
	wire is_bip = (sp.code <= `SPAN_BIP_LAST);
	wire is_uni = (sp.code > `SPAN_BIP_LAST) && (sp.code <= `SPAN_UNI_LAST);
	wire is_diff = (sp.code >= `SPAN_DIFF_FIRST) && (sp.code <= `SPAN_DIFF_LAST);
	// Codes above the last differential span drive no front-end class
	wire is_def = (sp.code <= `SPAN_DIFF_LAST);

	// Registered so the front end sees glitch-free selects
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sp.bipolar <= 1'b1;
			sp.unipolar <= 1'b0;
			sp.differential <= 1'b0;
			sp.defined <= 1'b1;
		end else begin
			sp.bipolar <= is_bip;
			sp.unipolar <= is_uni;
			sp.differential <= is_diff;
			sp.defined <= is_def;
		end
	end

endmodule

// ==== design/adc_channel_config_regs.sv ====
// APB register bank for spans, bandwidth, averaging and channel 1 gain
//
// How it works
// - Channels 3 to 8 each have a 4-bit span field; even channel high nibble, odd low.
// - Codes 0 to 4 select bipolar single-ended spans 2.5 to 12.5 V.
// - Codes 5 to 7 select unipolar spans 0-5, 0-10, 0-12.5 V.
// - Codes 8 to 11 select differential spans 5, 10, 12.5, 20 V.
// - Every span pair register resets to 0x33, the 10 V single-ended span.
// - Span pairs 3/4, 5/6, 7/8 sit at 0x04, 0x05, 0x06, read-write.
// - Bandwidth bit n-1 puts channel n into wide mode; resets low.
// - Bandwidth register sits at 0x07 and resets to zero.
// - Ratio field [3:0]: 0 off, 1 to 8 average 2 to 256 samples.
// - Padding field [7:4] stretches the spacing between samples of an internally paced burst.
// - Averaging register sits at 0x08, resets to zero: off, no padding.
// - Channel 1 gain trim sits at 0x09 and resets to zero.
// - Gain trim is six bits, 1024 ohm a step; bits 7:6 read zero.
// - External clock mode: each start pin rising edge triggers one sample of the average.
`timescale 1ns/10ps
`include "adc_cfg.svh"
module adc_channel_config_regs
	import adc_cfg_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int GAP_CYC = (`SAMPLE_GAP_NS * `REF_CLK_MHZ + 999) / 1000,
	parameter int PAD_CYC = (`PAD_STEP_NS * `REF_CLK_MHZ + 999) / 1000
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Span selects per channel
	output logic [3:0] span_sel_third,
	output logic [3:0] span_sel_fourth,
	output logic [3:0] span_sel_fifth,
	output logic [3:0] span_sel_sixth,
	output logic [3:0] span_sel_seventh,
	output logic [3:0] span_sel_eighth,
	// Decoded span class, bit 0 is channel 3
	output logic [5:0] span_bipolar,
	output logic [5:0] span_unipolar,
	output logic [5:0] span_differential,
	output logic [5:0] span_defined,
	// Bandwidth, bit 0 is channel 1
	output logic [7:0] wide_filter_en,
	// Averaging settings and gain
	output logic [3:0] averaging_factor,
	output logic [3:0] averaging_padding,
	output logic external_averaging_clock_en,
	output logic [5:0] gain_trim_first,
	// Conversion start pin and sample sequencing
	input wire logic conversion_start_pin,
	output logic sample_trigger,
	output logic average_done
);

	localparam int NCH = 6;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] GAP_C = CNT_W'(GAP_CYC);
	localparam logic [CNT_W-1:0] PAD_C = CNT_W'(PAD_CYC);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [`REG_W-1:0] range_select_ch3_ch4_r;
	logic [`REG_W-1:0] range_select_ch5_ch6_r;
	logic [`REG_W-1:0] range_select_ch7_ch8_r;
	logic [`REG_W-1:0] high_bandwidth_enables_r;
	logic [`REG_W-1:0] averaging_control_r;
	logic [`GAIN_W-1:0] gain_trim_ch1_r;
	logic mode_ext_clk_r;
	logic [31:0] prdata_r;
	logic pslverr_r;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Registers are byte wide in lane 0; other lanes are ignored
	wire [`IDX_W-1:0] word_idx = `IDX_W'(paddr[ADDR_W-1:2]);
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire wr_en = access_ph && pwrite && pstrb[0];
	wire [`REG_W-1:0] wbyte = pwdata[`REG_W-1:0];
	wire hit_r34 = (word_idx == `IDX_RANGE_34);
	wire hit_r56 = (word_idx == `IDX_RANGE_56);
	wire hit_r78 = (word_idx == `IDX_RANGE_78);
	wire hit_bw = (word_idx == `IDX_BANDWIDTH);
	wire hit_avg = (word_idx == `IDX_AVERAGING);
	wire hit_gain = (word_idx == `IDX_GAIN_CH1);
	wire hit_mode = (word_idx == `IDX_MODE_CTRL);
	wire hit_stat = (word_idx == `IDX_SEQ_STATUS);
	wire hit_any = hit_r34 | hit_r56 | hit_r78 | hit_bw | hit_avg | hit_gain | hit_mode | hit_stat;
	// Status is read-only; writing it is an error
	wire bad_acc = !hit_any || (pwrite && hit_stat);

	// Zero wait states; answer prepared during setup
	assign pready = access_ph;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r && access_ph;

	// ----------------------------------------------------------------
	// Averaging sequencer signals
	// ----------------------------------------------------------------
	os_state_t os_state_r;
	os_state_t os_state_nxt;
	logic [8:0] left_r;
	logic [8:0] left_nxt;
	logic [CNT_W-1:0] gap_r;
	logic [CNT_W-1:0] gap_nxt;
	logic trig_nxt;
	logic done_nxt;
	logic trig_r;
	logic done_r;
	logic cs_meta_r;
	logic cs_sync_r;
	logic cs_prev_r;

	wire [3:0] ratio = averaging_control_r[`RATIO_MSB:`RATIO_LSB];
	wire [3:0] pad = averaging_control_r[`PAD_MSB:`PAD_LSB];
	// Reserved ratios behave as averaging off
	wire ratio_reserved = (ratio > `RATIO_MAX);
	wire os_on = (ratio != `RATIO_OFF) && !ratio_reserved;
	wire [8:0] total = os_on ? 9'(9'h001 << ratio) : 9'h001;
	wire [CNT_W-1:0] period = GAP_C + CNT_W'(pad) * PAD_C;
	wire cs_rise = cs_sync_r && !cs_prev_r;
	wire any_undef = ~&span_defined;

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire [7:0] stat_byte = {5'h00, ratio_reserved, any_undef, (os_state_r == OS_RUN)};
	wire [`REG_W-1:0] rd_byte =
		hit_r34 ? range_select_ch3_ch4_r :
		hit_r56 ? range_select_ch5_ch6_r :
		hit_r78 ? range_select_ch7_ch8_r :
		hit_bw ? high_bandwidth_enables_r :
		hit_avg ? averaging_control_r :
		hit_gain ? {2'b00, gain_trim_ch1_r} :
		hit_mode ? {7'h00, mode_ext_clk_r} :
		hit_stat ? stat_byte : 8'h00;

	// Read data and error latched in the setup cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r <= {24'h00_0000, rd_byte};
			pslverr_r <= bad_acc;
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Span pairs; all writable, reset to the 10 V single-ended code
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			range_select_ch3_ch4_r <= `RST_RANGE;
			range_select_ch5_ch6_r <= `RST_RANGE;
			range_select_ch7_ch8_r <= `RST_RANGE;
		end else if (wr_en) begin
			if (hit_r34) begin
				range_select_ch3_ch4_r <= wbyte;
			end
			if (hit_r56) begin
				range_select_ch5_ch6_r <= wbyte;
			end
			if (hit_r78) begin
				range_select_ch7_ch8_r <= wbyte;
			end
		end
	end

	// Bandwidth, averaging, gain and mode control
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			high_bandwidth_enables_r <= `RST_BANDWIDTH;
			averaging_control_r <= `RST_AVERAGING;
			gain_trim_ch1_r <= `RST_GAIN;
			mode_ext_clk_r <= `RST_MODE;
		end else if (wr_en) begin
			if (hit_bw) begin
				high_bandwidth_enables_r <= wbyte;
			end
			if (hit_avg) begin
				averaging_control_r <= wbyte;
			end
			if (hit_gain) begin
				gain_trim_ch1_r <= wbyte[`GAIN_MSB:`GAIN_LSB];
			end
			if (hit_mode) begin
				mode_ext_clk_r <= wbyte[`EXT_CLK_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Field outputs
	// ----------------------------------------------------------------
	// Odd channel in the low nibble, even channel in the high nibble
	assign span_sel_third = range_select_ch3_ch4_r[`ODD_MSB:`ODD_LSB];
	assign span_sel_fourth = range_select_ch3_ch4_r[`EVEN_MSB:`EVEN_LSB];
	assign span_sel_fifth = range_select_ch5_ch6_r[`ODD_MSB:`ODD_LSB];
	assign span_sel_sixth = range_select_ch5_ch6_r[`EVEN_MSB:`EVEN_LSB];
	assign span_sel_seventh = range_select_ch7_ch8_r[`ODD_MSB:`ODD_LSB];
	assign span_sel_eighth = range_select_ch7_ch8_r[`EVEN_MSB:`EVEN_LSB];
	assign wide_filter_en = high_bandwidth_enables_r;
	assign averaging_factor = ratio;
	assign averaging_padding = pad;
	assign external_averaging_clock_en = mode_ext_clk_r;
	assign gain_trim_first = gain_trim_ch1_r;

	// ----------------------------------------------------------------
	// Span decoders, one per channel
	// ----------------------------------------------------------------
	wire [4*NCH-1:0] span_all = {span_sel_eighth, span_sel_seventh, span_sel_sixth,
		span_sel_fifth, span_sel_fourth, span_sel_third};

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_span
			span_if sp ();
			// Selector in, registered class flags out
			assign sp.code = span_all[4*gi +: 4];
			assign span_bipolar[gi] = sp.bipolar;
			assign span_unipolar[gi] = sp.unipolar;
			assign span_differential[gi] = sp.differential;
			assign span_defined[gi] = sp.defined;
			span_decode u_dec (
				.ref_clk(ref_clk),
				.rst(rst),
				.sp(sp.dec)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Conversion start synchroniser
	// ----------------------------------------------------------------
	// Pin is asynchronous; edge found only on the second stage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cs_meta_r <= 1'b0;
			cs_sync_r <= 1'b0;
			cs_prev_r <= 1'b0;
		end else begin
			cs_meta_r <= conversion_start_pin;
			cs_sync_r <= cs_meta_r;
			cs_prev_r <= cs_sync_r;
		end
	end

	// ----------------------------------------------------------------
	// Averaging sequencer
	// ----------------------------------------------------------------
	// Settings are sampled each cycle; change them only while idle
	always_comb begin
		os_state_nxt = os_state_r;
		left_nxt = left_r;
		gap_nxt = gap_r;
		trig_nxt = 1'b0;
		done_nxt = 1'b0;
		unique case (os_state_r)
			OS_IDLE: begin
				if (cs_rise) begin
					trig_nxt = 1'b1;
					if (os_on) begin
						left_nxt = total - 9'h001;
						gap_nxt = period;
						os_state_nxt = OS_RUN;
					end else begin
						done_nxt = 1'b1;
					end
				end
			end
			OS_RUN: begin
				if (mode_ext_clk_r) begin
					// Host clock on the start pin paces every sample
					if (cs_rise) begin
						trig_nxt = 1'b1;
						left_nxt = left_r - 9'h001;
						if (left_r == 9'h001) begin
							done_nxt = 1'b1;
							os_state_nxt = OS_IDLE;
						end
					end
				end else if (gap_r <= 16'h0001) begin
					trig_nxt = 1'b1;
					left_nxt = left_r - 9'h001;
					gap_nxt = period;
					if (left_r == 9'h001) begin
						done_nxt = 1'b1;
						os_state_nxt = OS_IDLE;
					end
				end else begin
					gap_nxt = gap_r - 16'h0001;
				end
			end
		endcase
	end

	// Sequencer state and registered pulses
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			os_state_r <= OS_IDLE;
			left_r <= 9'h000;
			gap_r <= 16'h0000;
			trig_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			os_state_r <= os_state_nxt;
			left_r <= left_nxt;
			gap_r <= gap_nxt;
			trig_r <= trig_nxt;
			done_r <= done_nxt;
		end
	end

	assign sample_trigger = trig_r;
	assign average_done = done_r;

endmodule

// ==== verification/adc_cfg_monitor.sv ====
// Assertion checker for the channel configuration register bank
`timescale 1ns/10ps
module adc_cfg_monitor #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	// Fields and pulses
	input wire logic [3:0] span_sel_third,
	input wire logic [3:0] span_sel_fourth,
	input wire logic [3:0] span_sel_fifth,
	input wire logic [3:0] span_sel_eighth,
	input wire logic [5:0] span_bipolar,
	input wire logic [5:0] span_unipolar,
	input wire logic [5:0] span_differential,
	input wire logic [5:0] span_defined,
	input wire logic [7:0] wide_filter_en,
	input wire logic [3:0] averaging_factor,
	input wire logic [3:0] averaging_padding,
	input wire logic [5:0] gain_trim_first,
	input wire logic sample_trigger,
	input wire logic average_done
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Bus effects
	// ----------------------------------------
	// Only the low lane carries register data
	wire wr_go = psel && penable && pwrite && pstrb[0];
	wire rd_go = psel && penable && !pwrite;
	property p_wr34;
		wr_go && paddr == 12'h010 |=> {span_sel_fourth, span_sel_third} == $past(pwdata[7:0]);
	endproperty
	a_wr34: assert property (p_wr34) else $error("span pair 3/4 write lost");
	property p_rd34;
		rd_go && paddr == 12'h010 |-> prdata[7:0] == {span_sel_fourth, span_sel_third};
	endproperty
	a_rd34: assert property (p_rd34) else $error("span pair 3/4 read wrong");
	property p_bw;
		wr_go && paddr == 12'h01c |=> wide_filter_en == $past(pwdata[7:0]);
	endproperty
	a_bw: assert property (p_bw) else $error("bandwidth write lost");
	property p_avg;
		wr_go && paddr == 12'h020 |=> {averaging_padding, averaging_factor} == $past(pwdata[7:0]);
	endproperty
	a_avg: assert property (p_avg) else $error("averaging write lost");
	property p_gain;
		wr_go && paddr == 12'h024 |=> gain_trim_first == $past(pwdata[5:0]);
	endproperty
	a_gain: assert property (p_gain) else $error("gain write lost");
	property p_gainrd;
		rd_go && paddr == 12'h024 |-> prdata[7:0] == {2'b00, gain_trim_first};
	endproperty
	a_gainrd: assert property (p_gainrd) else $error("gain read wrong");
	// ----------------------------------------
	// Span decode, one cycle behind the field
	// ----------------------------------------
	property p_bip;
		span_sel_third <= 4'h4 |=> span_bipolar[0] && !span_unipolar[0];
	endproperty
	a_bip: assert property (p_bip) else $error("bipolar class wrong");
	property p_uni;
		span_sel_fifth inside {[4'h5:4'h7]} |=> span_unipolar[2] && !span_bipolar[2];
	endproperty
	a_uni: assert property (p_uni) else $error("unipolar class wrong");
	property p_diff;
		span_sel_eighth inside {[4'h8:4'hb]} |=> span_differential[5] && span_defined[5];
	endproperty
	a_diff: assert property (p_diff) else $error("differential class wrong");
	// ----------------------------------------
	// Sequencer pulses
	// ----------------------------------------
	property p_off;
		sample_trigger && averaging_factor == 4'h0 |-> average_done;
	endproperty
	a_off: assert property (p_off) else $error("single sample without done");
	property p_done;
		average_done |-> sample_trigger;
	endproperty
	a_done: assert property (p_done) else $error("done without sample");
endmodule
bind adc_channel_config_regs adc_cfg_monitor #(.ADDR_W(ADDR_W)) adc_cfg_monitor_inst (.ref_clk(ref_clk),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .span_sel_third(span_sel_third), .span_sel_fourth(span_sel_fourth),
	.span_sel_fifth(span_sel_fifth), .span_sel_eighth(span_sel_eighth), .span_bipolar(span_bipolar),
	.span_unipolar(span_unipolar), .span_differential(span_differential), .span_defined(span_defined),
	.wide_filter_en(wide_filter_en), .averaging_factor(averaging_factor),
	.averaging_padding(averaging_padding), .gain_trim_first(gain_trim_first),
	.sample_trigger(sample_trigger), .average_done(average_done));

// ==== verification/apb_host_model.sv ====
// Host model: bus master and conversion start pin
`timescale 1ns/10ps
module apb_host_model (
	// Clock
	input wire logic ref_clk,
	// Bus master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Start pin
	output logic conversion_start_pin
);
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb, conversion_start_pin} = '0;
	end
	// One transfer; request held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
	// Start edge held long enough for the pin synchroniser
	task automatic start_pulse();
		@(posedge ref_clk);
		conversion_start_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		conversion_start_pin <= 1'b0;
	endtask
endmodule

// ==== verification/tb_adc_channel_config_regs.sv ====
// Self-checking bench for the channel configuration register bank
`timescale 1ns/10ps
module tb_adc_channel_config_regs import adc_cfg_pkg::*; ;
	`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
		$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
	localparam int GAP = 2;
	localparam int PAD = 1;
	logic ref_clk;
	logic rst;
	wire psel, penable, pwrite, pready, pslverr, cs_pin, sample_trigger, average_done, ext_en;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [3:0] pstrb, s3, s4, s5, s6, s7, s8, fac, pad;
	wire [5:0] bip, uni, dif, def, gain;
	wire [7:0] wide;
	logic [31:0] q;
	logic er;
	logic [3:0] hi, lo;
	logic [2:0] kh, kl;
	int n_mismatch, checks_done, ntrig, ndone, cyc, b, d;
	int trig_at [0:1023];
	adc_channel_config_regs #(.ADDR_W(12), .GAP_CYC(GAP), .PAD_CYC(PAD)) adc_channel_config_regs_inst (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.span_sel_third(s3), .span_sel_fourth(s4), .span_sel_fifth(s5), .span_sel_sixth(s6),
		.span_sel_seventh(s7), .span_sel_eighth(s8), .span_bipolar(bip), .span_unipolar(uni),
		.span_differential(dif), .span_defined(def), .wide_filter_en(wide), .averaging_factor(fac),
		.averaging_padding(pad), .external_averaging_clock_en(ext_en), .gain_trim_first(gain),
		.conversion_start_pin(cs_pin), .sample_trigger(sample_trigger), .average_done(average_done));
	apb_host_model apb_host_model_inst (.ref_clk(ref_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conversion_start_pin(cs_pin));
	// ----------------------------------------
	// Clock, pulse log, watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (sample_trigger === 1'b1) begin
			trig_at[ntrig % 1024] <= cyc;
			ntrig <= ntrig + 1;
		end
		if (average_done === 1'b1) ndone <= ndone + 1;
	end
	// Longest run is well under this span
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		report_and_stop();
	end
	task automatic report_and_stop();
		if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	function automatic logic [2:0] cls(input logic [3:0] c);
		cls = {c <= 4'h4, c inside {[4'h5:4'h7]}, c inside {[4'h8:4'hb]}};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		apb_host_model_inst.xfer(1'b1, a, {24'h0, v}, 4'hf, q, er);
	endtask
	task automatic rd(input logic [11:0] a);
		apb_host_model_inst.xfer(1'b0, a, 32'h0, 4'hf, q, er);
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{n_mismatch, checks_done, ntrig, ndone, cyc} = '0;
		rst = 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		for (int a = 0; a < 6; a++) begin
			rd(12'h010 + 12'(4 * a));
			`CHK("reset", (a < 3) ? 32'h33 : 32'h0, q)
		end
		for (int c = 0; c < 12; c++) begin
			hi = 4'(c);
			lo = 4'(11 - c);
			for (int a = 0; a < 3; a++) wr(12'h010 + 12'(4 * a), {hi, lo});
			for (int a = 0; a < 3; a++) begin
				rd(12'h010 + 12'(4 * a));
				`CHK("range", {24'h0, hi, lo}, q)
			end
			kh = cls(hi);
			kl = cls(lo);
			`CHK("sel", {3{hi, lo}}, {s8, s7, s6, s5, s4, s3})
			`CHK("bip", {3{kh[2], kl[2]}}, bip)
			`CHK("uni", {3{kh[1], kl[1]}}, uni)
			`CHK("dif", {3{kh[0], kl[0]}}, dif)
			`CHK("def", 6'h3f, def)
		end
		wr(12'h01c, 8'ha5);
		apb_host_model_inst.xfer(1'b1, 12'h01c, 32'hff, 4'h0, q, er);
		rd(12'h01c);
		`CHK("bw", 32'ha5, q)
		`CHK("wide", 8'ha5, wide)
		wr(12'h024, 8'hff);
		rd(12'h024);
		`CHK("gain", 32'h3f, q)
		`CHK("gainout", 6'h3f, gain)
		rd(12'h100);
		`CHK("unmapped", 33'h1_0000_0000, {er, q})
		wr(12'h0c4, 8'h07);
		`CHK("rostat", 1'b1, er)
		for (int r = 0; r < 4; r++) begin
			wr(12'h020, 8'(r * 17));
			// Write lands at the access edge; look one edge later
			@(posedge ref_clk);
			`CHK("avg", {4'(r), 4'(r)}, {pad, fac})
			b = ntrig;
			d = ndone;
			apb_host_model_inst.start_pulse();
			repeat (80) @(posedge ref_clk);
			`CHK("trig", 1 << r, ntrig - b)
			`CHK("done", 1, ndone - d)
			if (r > 0) `CHK("gap", GAP + r * PAD, trig_at[b + 1] - trig_at[b])
		end
		wr(12'h0c0, 8'h01);
		wr(12'h020, 8'h01);
		`CHK("ext_en", 1'b1, ext_en)
		b = ntrig;
		d = ndone;
		for (int p = 0; p < 2; p++) begin
			apb_host_model_inst.start_pulse();
			repeat (20) @(posedge ref_clk);
			`CHK("ext", p + 1, ntrig - b)
			if (p == 0) begin
				// Burst waits for the host clock, so status shows busy
				rd(12'h0c4);
				`CHK("busy", 32'h1, q)
			end
		end
		`CHK("extdone", 1, ndone - d)
		report_and_stop();
	end
endmodule
